// file: pkg/flash_cmd_regs.svh
// register offsets, command codes and reset values of the flash command front end
`ifndef FLASH_CMD_REGS_SVH
`define FLASH_CMD_REGS_SVH
// identification offsets within a bank
`define OFS_MAKER      8'h00
`define OFS_PART_ONE   8'h01
`define OFS_SEC_LOCK   8'h02
`define OFS_INDICATOR  8'h03
`define OFS_PART_TWO   8'h0E
`define OFS_PART_THREE 8'h0F
// bank-relative unlock addresses
`define UNLOCK_ADDR_A  12'h555
`define UNLOCK_ADDR_B  12'h2AA
// command data words
`define CMD_UNLOCK_A   16'h00AA
`define CMD_UNLOCK_B   16'h0055
`define CMD_ID_ENTER   16'h0090
`define CMD_RESET      16'h00F0
`define CMD_PROGRAM    16'h00A0
`define CMD_CFG_READ   16'h00C6
`define CMD_CFG_WRITE  16'h00D0
`define CMD_SUSPEND    16'h00B0
`define CMD_RESUME     16'h0030
// configuration register default and field position
`define CFG_RESET      16'hAFC8
`define CFG_READ_MODE  15
// status bit positions
`define ST_POLL        7
`define ST_TOGGLE      6
`define ST_LIMIT       5
// indicator bit positions
`define IND_FACTORY    7
`define IND_CUSTOMER   6
`define IND_VOL_LOCK   1
`define IND_PERS_ERASE 0
`define BANK_BITS      4
`endif

// file: pkg/flash_cmd_pkg.sv
// types shared by the flash command front end
package flash_cmd_pkg;
    // unlock sequence decoder, gray along the usual path
    typedef enum logic [2:0] {
        CS_IDLE  = 3'b000,
        CS_UNLK1 = 3'b001,
        CS_UNLK2 = 3'b011,
        CS_PADDR = 3'b010,
        CS_CDATA = 3'b110
    } cmd_state_t;
    // embedded program engine
    typedef enum logic [1:0] {
        PG_IDLE  = 2'b00,
        PG_BUSY  = 2'b01,
        PG_SUSP  = 2'b11,
        PG_FAULT = 2'b10
    } prog_state_t;
endpackage

// file: logic/flash_autoselect_program_cmd.sv
// command interpreter, identification mode and program engine of a banked flash die
// Operation
// R01: four-cycle sequence exposes configuration register
// R02: host issues reset after configuration read
// R03: reset loads configuration defaults
// R04: lock check uses sector bits plus offset
// R05: third entry write top bits pick bank
// R06: other banks keep reading array data
// R07: entry accepted only from read state
// R08: host avoids entry during program or erase
// R09: reset command leaves identification mode
// R10: offsets give maker, part codes, lock
// R11: indicator word carries lock and option flags
// R12: entry is AA, 55, 90 at unlock addresses
// R13: reset write accepted at any offset
// R14: host strobes address then data
// R15: address on last fall, data first rise
// R16: program end returns bank to read
// R17: status reads show poll and toggle bits
// R18: clearing a zero sets limit, halts
// R19: busy program ignores all but suspend
// R20: no identification entry while programming
// R21: hardware reset aborts programming
// R22: program addresses in any order
// R23: host configures before programming
// R24: chip deselect keeps configuration
// R25: undefined identification reads return zero
`timescale 1ns/10ps
`include "flash_cmd_regs.svh"
module flash_autoselect_program_cmd #(
    parameter int             ADDR_W      = 24,    // word address width
    parameter int             MEM_AW      = 6,     // modelled array index width
    parameter int             SEC_BITS    = 4,     // sector select width
    parameter int             PROG_CYCLES = 40,    // embedded program duration
    parameter logic [15:0]    MAKER_CODE  = 16'h00A5, // arbitrary value
    parameter logic [15:0]    PART_ONE    = 16'h1234, // arbitrary value
    parameter logic [15:0]    PART_TWO    = 16'h5678, // arbitrary value
    parameter logic [15:0]    PART_THREE  = 16'h9ABC, // arbitrary value
    parameter bit             FACTORY_LCK = 1'b0,
    parameter bit             CUSTOM_LCK  = 1'b0,
    parameter bit             VOL_PWRUP   = 1'b0,
    parameter bit             PERS_ERASE  = 1'b1
) (
    input  wire logic                     mclk_i,
    input  wire logic                     sys_rst_i,
    input  wire logic                     addr_valid_n_i,
    input  wire logic                     ce_n_i,
    input  wire logic                     we_n_i,
    input  wire logic                     oe_n_i,
    input  wire logic [ADDR_W-1:0]        addr_i,
    input  wire logic [15:0]              dq_i,
    input  wire logic [2**SEC_BITS-1:0]   sector_lock_i,
    output logic      [15:0]              dq_o,
    output logic                          dq_oe_o,
    output logic                          read_mode_select_o,
    output flash_cmd_pkg::prog_state_t    prog_state_o
);
    import flash_cmd_pkg::*;

    localparam int SW = ADDR_W + 20;                  // synchronised bundle width
    localparam int CW = $clog2(PROG_CYCLES + 1);

    // refuse sizes the decode cannot serve
    if (ADDR_W < 12 + `BANK_BITS || MEM_AW > 12 || SEC_BITS > ADDR_W || PROG_CYCLES < 1) begin : g_bad
        $error("flash front end: unsupported parameter set");
    end

    logic [SW-1:0]         s1_q, s2_q, s3_q;          // three-stage pin synchroniser
    logic [3:0]            ctl_q, ctl_d;              // agreed {avd, ce, we, oe}
    logic                  wr_on_q, rd_on_q;          // previous strobe states
    logic [ADDR_W-1:0]     waddr_q, waddr_d;          // latched write address
    cmd_state_t            cst_q, cst_d;              // unlock decoder
    prog_state_t           pst_q, pst_d;              // program engine
    logic [CW-1:0]         cnt_q, cnt_d;              // program time left
    logic [MEM_AW-1:0]     pidx_q, pidx_d;            // program target word
    logic [3:0]            pbank_q, pbank_d;          // bank being programmed
    logic [15:0]           pdata_q, pdata_d;          // word being programmed
    logic                  id_q, id_d;                // identification mode
    logic [3:0]            idb_q, idb_d;              // bank in identification
    logic                  cfgr_q, cfgr_d;            // configuration read mode
    logic [15:0]           cfg_q, cfg_d;              // configuration register
    logic                  tog_q, tog_d;              // toggle status bit
    logic [15:0]           mem_q [2**MEM_AW];         // modelled array
    logic [15:0]           mem_d [2**MEM_AW];
    logic [15:0]           dq_d;
    logic                  wr_on, rd_on, wr_start, wr_end, rd_start;
    logic [ADDR_W-1:0]     raddr;
    logic [15:0]           wdata;

    function automatic logic [3:0] bank_of(input logic [ADDR_W-1:0] a);
        return a[ADDR_W-1 -: `BANK_BITS];
    endfunction

    function automatic logic [MEM_AW-1:0] idx_of(input logic [ADDR_W-1:0] a);
        return a[MEM_AW-1:0];
    endfunction

    // first stage feeds only the second; agreement of 2 and 3 counts
    always_ff @(posedge mclk_i) begin
        s1_q <= {addr_valid_n_i, ce_n_i, we_n_i, oe_n_i, dq_i, addr_i};
        s2_q <= s1_q;
        s3_q <= s2_q;
    end

    assign raddr    = s3_q[ADDR_W-1:0];
    assign wdata    = s3_q[ADDR_W +: 16];
    // write cycle needs ce and we low; read cycle needs ce and oe low with we high
    assign wr_on    = !ctl_q[2] && !ctl_q[1];
    assign rd_on    = !ctl_q[2] && !ctl_q[0] && ctl_q[1];
    assign wr_start = wr_on && !wr_on_q;
    assign wr_end   = !wr_on && wr_on_q;
    assign rd_start = rd_on && !rd_on_q;

    // command decode, program engine and mode state
    always_comb begin
        ctl_d   = (s2_q[SW-1 -: 4] == s3_q[SW-1 -: 4]) ? s3_q[SW-1 -: 4] : ctl_q;
        waddr_d = wr_start ? raddr : waddr_q;         // see R15
        cst_d   = cst_q;
        pst_d   = pst_q;
        cnt_d   = cnt_q;
        pidx_d  = pidx_q;
        pbank_d = pbank_q;
        pdata_d = pdata_q;
        id_d    = id_q;
        idb_d   = idb_q;
        cfgr_d  = cfgr_q;
        cfg_d   = cfg_q;                              // deselect leaves it alone, see R24
        tog_d   = tog_q;
        mem_d   = mem_q;
        // status reads flip the toggle bit while the engine owns the bank
        if (rd_start && pst_q != PG_IDLE && bank_of(raddr) == pbank_q) begin
            tog_d = !tog_q;                           // see R17
        end
        // engine countdown; suspended time does not count
        if (pst_q == PG_BUSY) begin
            if (cnt_q == '0) begin
                mem_d[pidx_q] = mem_q[pidx_q] & pdata_q;
                pst_d         = PG_IDLE;              // see R16
            end else begin
                cnt_d = cnt_q - 1'b1;
            end
        end
        // data is taken on the first rising strobe edge, see R15
        if (wr_end) begin
            case (pst_q)
                PG_BUSY: begin
                    // everything but suspend is dropped, see R19 R20 R08
                    if (wdata == `CMD_SUSPEND && cnt_q != '0) begin
                        pst_d = PG_SUSP;
                    end
                end
                PG_SUSP: begin
                    if (wdata == `CMD_RESUME) begin
                        pst_d = PG_BUSY;
                    end
                end
                PG_FAULT: begin
                    // only a reset command releases the halt, see R18
                    if (wdata == `CMD_RESET) begin
                        pst_d = PG_IDLE;
                        cst_d = CS_IDLE;
                    end
                end
                default: begin
                    if (wdata == `CMD_RESET && cst_q != CS_CDATA && cst_q != CS_PADDR) begin
                        // any offset leaves both read modes, see R09 R13 R02
                        id_d   = 1'b0;
                        cfgr_d = 1'b0;
                        cst_d  = CS_IDLE;
                    end else begin
                        case (cst_q)
                            CS_IDLE: begin
                                if (wdata == `CMD_UNLOCK_A && waddr_q[11:0] == `UNLOCK_ADDR_A) begin
                                    cst_d = CS_UNLK1;
                                end
                            end
                            CS_UNLK1: begin
                                cst_d = (wdata == `CMD_UNLOCK_B &&
                                         waddr_q[11:0] == `UNLOCK_ADDR_B) ? CS_UNLK2 : CS_IDLE;
                            end
                            CS_UNLK2: begin
                                cst_d = CS_IDLE;
                                if (waddr_q[11:0] == `UNLOCK_ADDR_A) begin
                                    case (wdata)
                                        `CMD_ID_ENTER: begin
                                            // every bank sits in read state here, see R07 R05
                                            id_d  = 1'b1;
                                            idb_d = bank_of(waddr_q);
                                        end
                                        `CMD_PROGRAM:   cst_d  = CS_PADDR;
                                        `CMD_CFG_READ:  cfgr_d = 1'b1;      // see R01
                                        `CMD_CFG_WRITE: cst_d  = CS_CDATA;
                                        default:        cst_d  = CS_IDLE;
                                    endcase
                                end
                            end
                            CS_PADDR: begin
                                // any word of any sector, see R22
                                cst_d   = CS_IDLE;
                                pidx_d  = idx_of(waddr_q);
                                pbank_d = bank_of(waddr_q);
                                pdata_d = wdata;
                                cnt_d   = CW'(PROG_CYCLES - 1);
                                if ((wdata & ~mem_q[idx_of(waddr_q)]) != 16'h0000) begin
                                    pst_d = PG_FAULT;         // cell keeps its zero, see R18
                                end else begin
                                    pst_d = PG_BUSY;
                                end
                            end
                            CS_CDATA: begin
                                cfg_d = wdata;
                                cst_d = CS_IDLE;
                            end
                            default: cst_d = CS_IDLE;
                        endcase
                    end
                end
            endcase
        end
    end

    // read data path; undefined identification offsets give zero
    always_comb begin
        dq_d = mem_q[idx_of(raddr)];                  // normal array read, see R06
        if (pst_q != PG_IDLE && pst_q != PG_SUSP && bank_of(raddr) == pbank_q) begin
            dq_d                = 16'h0000;
            dq_d[`ST_POLL]      = (pst_q == PG_FAULT) ? pdata_q[`ST_POLL] : !pdata_q[`ST_POLL];
            dq_d[`ST_TOGGLE]    = tog_q;              // see R17
            dq_d[`ST_LIMIT]     = (pst_q == PG_FAULT);
        end else if (cfgr_q) begin
            dq_d = cfg_q;                             // see R01
        end else if (id_q && bank_of(raddr) == idb_q) begin
            dq_d = 16'h0000;                          // see R25
            case (raddr[7:0])                         // see R10
                `OFS_MAKER:      dq_d = MAKER_CODE;
                `OFS_PART_ONE:   dq_d = PART_ONE;
                `OFS_PART_TWO:   dq_d = PART_TWO;
                `OFS_PART_THREE: dq_d = PART_THREE;
                `OFS_SEC_LOCK:   dq_d[0] = sector_lock_i[raddr[ADDR_W-1 -: SEC_BITS]]; // see R04
                `OFS_INDICATOR: begin                 // bits 5:2 stay zero, see R11
                    dq_d[`IND_FACTORY]    = FACTORY_LCK;
                    dq_d[`IND_CUSTOMER]   = CUSTOM_LCK;
                    dq_d[`IND_VOL_LOCK]   = VOL_PWRUP;
                    dq_d[`IND_PERS_ERASE] = PERS_ERASE;
                end
                default:         dq_d = 16'h0000;
            endcase
        end
    end

    // state registers; hardware reset aborts programming, see R21 R03
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            ctl_q   <= 4'hF;
            wr_on_q <= 1'b0;
            rd_on_q <= 1'b0;
            waddr_q <= '0;
            cst_q   <= CS_IDLE;
            pst_q   <= PG_IDLE;
            cnt_q   <= '0;
            pidx_q  <= '0;
            pbank_q <= '0;
            pdata_q <= 16'h0000;
            id_q    <= 1'b0;
            idb_q   <= '0;
            cfgr_q  <= 1'b0;
            cfg_q   <= `CFG_RESET;
            tog_q   <= 1'b0;
            dq_o    <= 16'h0000;
            dq_oe_o <= 1'b0;
        end else begin
            ctl_q   <= ctl_d;
            wr_on_q <= wr_on;
            rd_on_q <= rd_on;
            waddr_q <= waddr_d;
            cst_q   <= cst_d;
            pst_q   <= pst_d;
            cnt_q   <= cnt_d;
            pidx_q  <= pidx_d;
            pbank_q <= pbank_d;
            pdata_q <= pdata_d;
            id_q    <= id_d;
            idb_q   <= idb_d;
            cfgr_q  <= cfgr_d;
            cfg_q   <= cfg_d;
            tog_q   <= tog_d;
            dq_o    <= dq_d;
            dq_oe_o <= rd_on;
        end
    end

    // array contents survive reset, like flash cells
    always_ff @(posedge mclk_i) begin
        mem_q <= mem_d;
    end

    assign read_mode_select_o = cfg_q[`CFG_READ_MODE];
    assign prog_state_o       = pst_q;

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (sys_rst_i);

    sequence s_wr_cmd(logic [15:0] c);
        wr_end && wdata == c;
    endsequence
    // entry word fused with the decoder state it needs
    sequence s_id_enter;
        s_wr_cmd(`CMD_ID_ENTER) ##0 (cst_q == CS_UNLK2 && pst_q == PG_IDLE
            && waddr_q[11:0] == `UNLOCK_ADDR_A);
    endsequence

    chk_cfg_default: assert property (disable iff (1'b0) // see R03
        sys_rst_i |=> cfg_q == `CFG_RESET) else $error("config not defaulted");
    chk_id_bank: assert property ( // see R05
        s_id_enter |=> id_q && idb_q == $past(bank_of(waddr_q))) else $error("bad id bank");
    chk_id_exit: assert property ( // see R09
        s_wr_cmd(`CMD_RESET) ##0 (pst_q == PG_IDLE
            && cst_q inside {CS_IDLE, CS_UNLK1, CS_UNLK2})
        |=> !id_q && !cfgr_q) else $error("reset did not exit");
    chk_maker_read: assert property ( // see R10
        rd_on && id_q && !cfgr_q && pst_q == PG_IDLE && bank_of(raddr) == idb_q
        && raddr[7:0] == `OFS_MAKER |=> dq_o == MAKER_CODE) else $error("maker code wrong");
    chk_other_bank: assert property ( // see R06
        rd_on && id_q && !cfgr_q && pst_q == PG_IDLE && bank_of(raddr) != idb_q
        |=> dq_o == $past(mem_q[idx_of(raddr)])) else $error("other bank not array");
    chk_busy_noid: assert property ( // see R20
        pst_q == PG_BUSY && !id_q ##0 s_wr_cmd(`CMD_ID_ENTER) |=> !id_q)
        else $error("id entered while busy");
    chk_limit_hold: assert property ( // see R18
        (pst_q == PG_FAULT && !(wr_end && wdata == `CMD_RESET)) [*2]
        |=> pst_q == PG_FAULT) else $error("fault lost");
    // a word that passed the fault test ends up holding exactly its data
    chk_prog_done: assert property ( // see R16
        pst_q == PG_BUSY && cnt_q == '0
        |=> pst_q == PG_IDLE ##0 mem_q[$past(pidx_q)] == $past(pdata_q))
        else $error("program did not finish");
    chk_addr_latch: assert property ( // see R15
        wr_start |=> waddr_q == $past(raddr) ##1 !wr_start [*1]) else $error("addr latch");
endmodule

// file: tb/host_bus_model.sv
// host controller model driving the flash parallel pins
`timescale 1ns/10ps
module host_bus_model (
    input  wire logic        mclk_i,
    input  wire logic [15:0] rd_data_i,
    output logic             avd_n_o,
    output logic             ce_n_o,
    output logic             we_n_o,
    output logic             oe_n_o,
    output logic [23:0]      addr_o,
    output logic [15:0]      wdata_o
);
    // each strobe level outlasts the device's four-cycle pin filter
    localparam int HOLD = 6;
    // idle pins at time zero
    initial begin
        avd_n_o = 1'b1;
        ce_n_o  = 1'b1;
        we_n_o  = 1'b1;
        oe_n_o  = 1'b1;
        addr_o  = 24'h000000;
        wdata_o = 16'h0000;
    end
    // address phase, then write strobe; data is held past the rising edge
    task automatic wr(input logic [23:0] a, input logic [15:0] d);
        @(negedge mclk_i);
        addr_o  = a;
        wdata_o = d;
        avd_n_o = 1'b0;
        ce_n_o  = 1'b0;
        repeat (HOLD) @(negedge mclk_i);
        avd_n_o = 1'b1;
        we_n_o  = 1'b0;
        repeat (HOLD) @(negedge mclk_i);
        we_n_o  = 1'b1; // first rise ends the write
        ce_n_o  = 1'b1;
        repeat (HOLD) @(negedge mclk_i);
        wdata_o = ~d; // released bus must not keep showing the word
    endtask
    // asynchronous read: data sampled once it has settled
    task automatic rd(input logic [23:0] a, output logic [15:0] d);
        @(negedge mclk_i);
        addr_o = a;
        ce_n_o = 1'b0;
        oe_n_o = 1'b0;
        repeat (HOLD) @(negedge mclk_i);
        d      = rd_data_i;
        ce_n_o = 1'b1;
        oe_n_o = 1'b1;
        repeat (HOLD) @(negedge mclk_i);
    endtask
endmodule

// file: tb/tb.sv
// self-checking bench of the flash command front end
`timescale 1ns/10ps
`include "flash_cmd_regs.svh"
module tb;
    import flash_cmd_pkg::*;
    localparam int PROG_N = 120; // room for status reads while busy
    localparam logic [15:0] MK = 16'h0A0B; // arbitrary value
    localparam logic [15:0] P1 = 16'h1C2D; // arbitrary value
    localparam logic [15:0] P2 = 16'h3E4F; // arbitrary value
    localparam logic [15:0] P3 = 16'h5061; // arbitrary value
    logic        mclk, sys_rst, avd_n, ce_n, we_n, oe_n, dq_oe, rms;
    logic [23:0] addr;
    logic [15:0] wdata, rdata, lock;
    prog_state_t pstate;
    int          error_cnt, cmp_count;
    int          mem [int]; // reference array contents
    // design under test
    flash_autoselect_program_cmd #(.PROG_CYCLES(PROG_N), .MAKER_CODE(MK), .PART_ONE(P1),
        .PART_TWO(P2), .PART_THREE(P3), .FACTORY_LCK(1'b1), .VOL_PWRUP(1'b1),
        .PERS_ERASE(1'b0)) u_flash_autoselect_program_cmd (
        .mclk_i(mclk), .sys_rst_i(sys_rst), .addr_valid_n_i(avd_n), .ce_n_i(ce_n),
        .we_n_i(we_n), .oe_n_i(oe_n), .addr_i(addr), .dq_i(wdata), .sector_lock_i(lock),
        .dq_o(rdata), .dq_oe_o(dq_oe), .read_mode_select_o(rms), .prog_state_o(pstate));
    // host side of the pins
    host_bus_model u_host_bus_model (
        .mclk_i(mclk), .rd_data_i(rdata), .avd_n_o(avd_n), .ce_n_o(ce_n), .we_n_o(we_n),
        .oe_n_o(oe_n), .addr_o(addr), .wdata_o(wdata));
    // 25 MHz clock
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    // one comparison, counted
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop();
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // two unlock cycles then the command word at the bank's unlock address
    task automatic unlock(input logic [3:0] b, input logic [15:0] c);
        u_host_bus_model.wr({b, 8'h00, `UNLOCK_ADDR_A}, `CMD_UNLOCK_A);
        u_host_bus_model.wr({b, 8'h00, `UNLOCK_ADDR_B}, `CMD_UNLOCK_B);
        u_host_bus_model.wr({b, 8'h00, `UNLOCK_ADDR_A}, c);
    endtask
    task automatic prog(input logic [23:0] a, input logic [15:0] d);
        unlock(a[23:20], `CMD_PROGRAM);
        u_host_bus_model.wr(a, d);
    endtask
    // bounded wait for an engine state
    task automatic wait_state(input prog_state_t s);
        int n;
        n = 0;
        while (pstate !== s && n < 400) begin
            @(negedge mclk);
            n++;
        end
        check({14'h0, pstate}, {14'h0, s});
    endtask
    // read with output enable seen high at sampling and low once released
    task automatic rdchk(input logic [23:0] a, input logic [15:0] exp);
        logic [15:0] r;
        fork
            u_host_bus_model.rd(a, r);
            begin
                repeat (7) @(negedge mclk);
                check({15'h0, dq_oe}, 16'h0001);
            end
        join
        check(r, exp);
        check({15'h0, dq_oe}, 16'h0000);
    endtask
    // hang guard, far beyond the roughly 1300 cycles the tests need
    initial begin
        repeat (20000) @(posedge mclk);
        error_cnt++;
        report_and_stop();
    end
    initial begin
        logic [15:0] v, r, r2;
        logic [23:0] a0, ab;
        logic [7:0]  ofs [6];
        logic [15:0] exv [6];
        ofs = '{8'h00, 8'h01, 8'h0E, 8'h0F, 8'h03, 8'h05};
        exv = '{MK, P1, P2, P3, 16'h0082, 16'h0000};
        error_cnt = 0;
        cmp_count = 0;
        sys_rst   = 1'b1;
        lock      = 16'h0000;
        v = 16'($urandom(32'h007697ad));
        repeat (16) @(negedge mclk);
        sys_rst = 1'b0;
        check({15'h0, rms}, 16'h0001);
        check({14'h0, pstate}, 16'h0000);
        unlock(4'h0, `CMD_CFG_READ);
        rdchk({4'h0, 20'($urandom)}, `CFG_RESET);
        u_host_bus_model.wr(24'h000000, `CMD_RESET);
        // configure before any programming, with read mode bit cleared
        v = 16'($urandom) & 16'h7FFF;
        unlock(4'h0, `CMD_CFG_WRITE);
        u_host_bus_model.wr(24'h000000, v);
        repeat (20) @(negedge mclk);
        check({15'h0, rms}, 16'h0000);
        unlock(4'h0, `CMD_CFG_READ);
        rdchk(24'h000000, v);
        u_host_bus_model.wr(24'h000000, `CMD_RESET);
        // program with status reads and a refused entry while busy
        a0 = 24'h000000;
        ab = {4'(1 + $urandom % 15), 14'($urandom), 6'h03};
        prog(a0, 16'h0000);
        u_host_bus_model.rd(a0, r);
        u_host_bus_model.rd(a0, r2);
        check({15'h0, r[7]}, 16'h0001);
        check({15'h0, r[6] ^ r2[6]}, 16'h0001);
        unlock(4'h0, `CMD_ID_ENTER);
        check({14'h0, pstate}, {14'h0, PG_BUSY});
        wait_state(PG_IDLE);
        mem[a0] = 0;
        rdchk(a0, 16'(mem[a0]));
        prog(ab, 16'h0000);
        wait_state(PG_IDLE);
        mem[ab] = 0;
        rdchk(ab, 16'(mem[ab]));
        // identification mode in bank 0, upper sector bits ignored
        unlock(4'h0, `CMD_ID_ENTER);
        for (int i = 0; i < 6; i++) begin
            rdchk({4'h0, 12'($urandom), ofs[i]}, exv[i]);
        end
        for (int i = 0; i < 2; i++) begin
            @(negedge mclk);
            lock = {16'($urandom)} & 16'hFFFE | 16'(i);
            rdchk({4'h0, 12'($urandom), `OFS_SEC_LOCK}, 16'(i));
        end
        rdchk(ab, 16'(mem[ab]));
        u_host_bus_model.wr({4'(ab[23:20]), 20'($urandom)}, `CMD_RESET);
        rdchk(a0, 16'(mem[a0]));
        // setting a bit over a stored zero faults until reset command
        prog(a0, 16'h0080);
        wait_state(PG_FAULT);
        u_host_bus_model.rd(a0, r);
        check({15'h0, r[5]}, 16'h0001);
        unlock(4'h0, `CMD_ID_ENTER);
        check({14'h0, pstate}, {14'h0, PG_FAULT});
        u_host_bus_model.wr(24'h000000, `CMD_RESET);
        wait_state(PG_IDLE);
        rdchk(a0, 16'(mem[a0]));
        // hardware reset in mid-program
        prog(24'h000005, 16'h0000);
        repeat (8) @(negedge mclk);
        check({14'h0, pstate}, {14'h0, PG_BUSY});
        sys_rst = 1'b1;
        repeat (4) @(negedge mclk);
        sys_rst = 1'b0;
        check({14'h0, pstate}, 16'h0000);
        check({15'h0, rms}, 16'h0001);
        unlock(4'h0, `CMD_CFG_READ);
        rdchk(24'h000000, `CFG_RESET);
        u_host_bus_model.wr(24'h000000, `CMD_RESET);
        report_and_stop();
    end
endmodule
